// file: src/pdfp_post_divider.sv
/*
 Post-divider C of the second synthesizer: byte register port, mode decode,
 50% divider for regular and low-frequency clocks, and frame pulse timing
 against a sibling post-divider clock.
 Assumes i_mclk is the synthesizer output, i_base_tick a one-cycle pulse
 at the base frequency, and sibling clocks are levels made on i_mclk.
*/
`timescale 1ns/10ps
// Functional notes
// RULE1: the top four bits pick frame pulse or low-frequency clock when all ones, else a divided clock.
// RULE2: all ones with selector 10 gives a 50% clock at the base frequency over the low sixteen bits.
// RULE3: all ones with any other selector gives a frame pulse one sibling clock period wide.
// RULE4: in frame mode the low sixteen bits count sibling periods between two frame pulses.
// RULE5: in low-frequency mode the low sixteen bits are the division factor of the base frequency.
// RULE6: selector 00 is divider A, 01 divider B, 10 low-frequency mode, 11 divider D.
// RULE7: polarity bit 0 gives a positive pulse and 1 a negative pulse.
// RULE8: style bit 0 gives an ST-Bus pulse centred on the frame boundary.
// RULE9: style bit 1 gives a GCI pulse whose first edge is the frame boundary.
// RULE10: outside the special code all 24 bits form one ratio applied to the synthesizer output with 50% duty.
// RULE11: polarity, style and selector bits serve only as ratio bits outside the modes that use them.
// RULE12: the configuration register resets to all zeros.
// RULE13: a new configuration takes effect only once all three bytes are written, restarting the counters.
module pdfp_post_divider
    import pdfp_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire pdfp_reg_req_t i_reg,
    input wire logic i_base_tick,
    input wire pdfp_sib_t i_sib,
    output logic [7:0] o_reg_rdata,
    output logic o_out
);

    typedef struct packed {
        logic [7:0] rdata;
        logic out;
        logic sib_prev;
        logic [15:0] fp_cnt;
        logic fp_active;
    } pdfp_top_state_t;

    pdfp_top_state_t s_q;
    pdfp_top_state_t s_d;

    pdfp_cfg_t cfg;
    logic commit;
    pdfp_mode_t mode;
    logic div_tick;
    logic [23:0] div_ratio;
    logic div_clk;
    logic sib_sel;
    logic sib_rise;
    logic sib_fall;
    logic [15:0] fp_last;
    logic fp_wrap;

    pdfp_cfg_regs u_cfg (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_req(i_reg),
        .o_cfg(cfg),
        .o_commit(commit)
    );

    // mode decode
    always_comb begin
        if (cfg.func != FUNC_SPECIAL) begin
            mode = MODE_DIV; // RULE1
        end else if (cfg.sel == SEL_LOW_FREQ) begin
            mode = MODE_LOW_FREQ; // RULE2
        end else begin
            mode = MODE_FRAME; // RULE3
        end
    end

    // divider feed: full ratio, or base-frequency ticks over the low field
    always_comb begin
        unique case (mode)
            MODE_DIV: begin
                div_tick = 1'b1;
                div_ratio = cfg; // RULE10 RULE11
            end
            MODE_LOW_FREQ: begin
                div_tick = i_base_tick;
                div_ratio = {BYTE_ZERO, cfg.rate}; // RULE5
            end
            MODE_FRAME: begin
                div_tick = 1'b0;
                div_ratio = '0;
            end
            default: begin
                div_tick = 1'b0;
                div_ratio = '0;
            end
        endcase
    end

    pdfp_clk_div u_div (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_restart(commit),
        .i_tick(div_tick),
        .i_ratio(div_ratio),
        .o_clk(div_clk)
    );

    // reference clock for frame width and spacing
    always_comb begin
        unique case (cfg.sel)
            SEL_CLK_A: sib_sel = i_sib.a; // RULE6
            SEL_CLK_B: sib_sel = i_sib.b; // RULE6
            SEL_LOW_FREQ: sib_sel = 1'b0; // RULE6
            SEL_CLK_D: sib_sel = i_sib.d; // RULE6
        endcase
    end

    assign sib_rise = sib_sel & ~s_q.sib_prev;
    assign sib_fall = ~sib_sel & s_q.sib_prev;

    // a zero spacing is taken as one period, as a zero divide cannot be met
    assign fp_last = (cfg.rate == RATE_ZERO) ? RATE_ZERO : cfg.rate - RATE_ONE; // RULE4
    assign fp_wrap = (s_q.fp_cnt >= fp_last);

    always_comb begin
        s_d = s_q;
        s_d.sib_prev = sib_sel;

        // readback shows the committed value, not a half-written shadow
        s_d.rdata = BYTE_ZERO;
        for (int i = 0; i < CFG_BYTES; i++) begin
            if (i_reg.addr == ADDR_CFG_LO - 8'(i)) begin
                s_d.rdata = cfg[i*BYTE_W +: BYTE_W];
            end
        end

        if (commit || mode != MODE_FRAME) begin
            s_d.fp_cnt = RATE_ZERO; // RULE13
            s_d.fp_active = 1'b0;
        end else begin
            // count sibling periods; the wrapping rise is the frame boundary
            if (sib_rise) begin
                s_d.fp_cnt = fp_wrap ? RATE_ZERO : s_q.fp_cnt + RATE_ONE; // RULE4
            end
            if (cfg.gci) begin
                // boundary rise opens the pulse, the next rise closes it
                if (sib_rise) begin
                    s_d.fp_active = fp_wrap; // RULE9 RULE3
                end
            end else begin
                // falls half a period either side of the boundary rise
                if (sib_fall) begin
                    s_d.fp_active = fp_wrap; // RULE8 RULE3
                end
            end
        end

        unique case (mode)
            MODE_DIV: s_d.out = div_clk;
            MODE_LOW_FREQ: s_d.out = div_clk;
            MODE_FRAME: s_d.out = s_d.fp_active ^ cfg.neg_pol; // RULE7
            default: s_d.out = 1'b0;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_reg_rdata = s_q.rdata;
    assign o_out = s_q.out;

    default clocking cb @(posedge i_mclk);
    endclocking

    default disable iff (i_rst);

    sequence seq_frame_steady;
        mode == MODE_FRAME && !commit;
    endsequence

    sequence seq_gci_boundary;
        seq_frame_steady ##0 cfg.gci && sib_rise && fp_wrap;
    endsequence

    sequence seq_st_lead;
        seq_frame_steady ##0 !cfg.gci && sib_fall && fp_wrap;
    endsequence

    AST_MODE_DIV: assert property (cfg.func != FUNC_SPECIAL |-> mode == MODE_DIV) // RULE1
        else $error("non-special code did not select the divider");

    AST_MODE_LOW_FREQ: assert property (
        cfg.func == FUNC_SPECIAL && cfg.sel == SEL_LOW_FREQ |-> mode == MODE_LOW_FREQ) // RULE2
        else $error("selector 10 did not select low-frequency mode");

    AST_MODE_FRAME: assert property (
        cfg.func == FUNC_SPECIAL && cfg.sel != SEL_LOW_FREQ |-> mode == MODE_FRAME) // RULE3
        else $error("special code did not select frame pulse mode");

    AST_RATIO_FULL: assert property (mode == MODE_DIV |-> div_ratio == cfg && div_tick) // RULE11
        else $error("divider ratio is not the full register");

    AST_RATIO_LOW: assert property (
        mode == MODE_LOW_FREQ |-> div_ratio == {BYTE_ZERO, cfg.rate} && div_tick == i_base_tick) // RULE5
        else $error("low-frequency divider not fed from the low field");

    AST_SEL_D: assert property (cfg.sel == SEL_CLK_D |-> sib_sel == i_sib.d) // RULE6
        else $error("selector 11 did not pick divider D");

    // output level was formed with the setting of the cycle before, which a commit may since have replaced
    AST_GCI_EDGE: assert property (
        seq_gci_boundary |=> s_q.fp_active && o_out != $past(cfg.neg_pol)) // RULE9
        else $error("GCI pulse did not open at the boundary");

    AST_ST_LEAD: assert property (
        seq_st_lead |=> s_q.fp_active && o_out != $past(cfg.neg_pol)) // RULE8
        else $error("ST-Bus pulse did not open half a period early");

    AST_GCI_CLOSE: assert property (
        seq_frame_steady ##0 cfg.gci && sib_rise && !fp_wrap |=> !s_q.fp_active) // RULE9
        else $error("GCI pulse did not close at the next rise");

    AST_ST_CLOSE: assert property (
        seq_frame_steady ##0 !cfg.gci && sib_fall && !fp_wrap |=> !s_q.fp_active) // RULE8
        else $error("ST-Bus pulse did not close at the next fall");

    AST_WIDTH_ST: assert property (
        seq_frame_steady ##0 !cfg.gci && !sib_fall && s_q.fp_active |=> s_q.fp_active) // RULE3
        else $error("ST-Bus pulse closed before a full period");

    AST_SEL_A: assert property (cfg.sel == SEL_CLK_A |-> sib_sel == i_sib.a) // RULE6
        else $error("selector 00 did not pick divider A");

    AST_SEL_B: assert property (cfg.sel == SEL_CLK_B |-> sib_sel == i_sib.b) // RULE6
        else $error("selector 01 did not pick divider B");

    AST_SEL_LOW: assert property (cfg.sel == SEL_LOW_FREQ |-> !sib_sel) // RULE6
        else $error("selector 10 picked a sibling clock");

    AST_DIV_OUT: assert property (mode == MODE_DIV |=> o_out == $past(div_clk)) // RULE10
        else $error("divided clock not passed to the output");

    AST_LOW_OUT: assert property (mode == MODE_LOW_FREQ |=> o_out == $past(div_clk)) // RULE2
        else $error("low-frequency clock not passed to the output");

    AST_FRAME_OUT: assert property (
        mode == MODE_FRAME |=> o_out == (s_q.fp_active ^ $past(cfg.neg_pol))) // RULE7
        else $error("frame output does not follow pulse and polarity");

    AST_SPACING_WRAP: assert property (
        seq_frame_steady ##0 sib_rise && fp_wrap |=> s_q.fp_cnt == RATE_ZERO) // RULE4
        else $error("frame spacing counter did not wrap at the boundary");

    AST_SPACING_HOLD: assert property (
        seq_frame_steady ##0 !sib_rise |=> s_q.fp_cnt == $past(s_q.fp_cnt)) // RULE4
        else $error("frame spacing counter moved without a rise");

    AST_IDLE_CNT: assert property (mode != MODE_FRAME |=> s_q.fp_cnt == RATE_ZERO && !s_q.fp_active) // RULE1
        else $error("frame counters ran outside frame mode");

    AST_RDATA_LO: assert property (i_reg.addr == ADDR_CFG_LO |=> o_reg_rdata == $past(cfg[7:0])) // RULE13
        else $error("low byte readback is not the committed value");

    AST_RDATA_HI: assert property (i_reg.addr == ADDR_CFG_HI |=> o_reg_rdata == $past(cfg[23:16])) // RULE13
        else $error("high byte readback is not the committed value");

    AST_WIDTH_GCI: assert property (
        seq_frame_steady ##0 cfg.gci && !sib_rise && s_q.fp_active |=> s_q.fp_active) // RULE3
        else $error("GCI pulse closed before a full period");

    AST_SPACING: assert property (
        seq_frame_steady ##0 sib_rise && !fp_wrap |=> s_q.fp_cnt == $past(s_q.fp_cnt) + RATE_ONE) // RULE4
        else $error("frame spacing counter did not advance");

    AST_POLARITY: assert property (
        seq_frame_steady ##0 !s_q.fp_active && !s_d.fp_active |=> o_out == $past(cfg.neg_pol)) // RULE7
        else $error("idle level does not follow the polarity bit");

    AST_RESTART: assert property (commit |=> s_q.fp_cnt == RATE_ZERO && !s_q.fp_active) // RULE13
        else $error("commit did not restart the frame counters");

endmodule

// file: src/pdfp_pkg.sv
/*
 Shared constants and types of post-divider C: register byte addresses,
 configuration field layout, output modes and bus carrier.
 Assumes nothing of its surroundings.
*/
package pdfp_pkg;

    // byte addresses of the 24-bit configuration, high byte first
    localparam logic [7:0] ADDR_CFG_HI = 8'h9E;
    localparam logic [7:0] ADDR_CFG_MID = 8'h9F;
    localparam logic [7:0] ADDR_CFG_LO = 8'hA0;
    localparam int CFG_BYTES = 3;
    localparam int BYTE_W = 8;

    localparam logic [23:0] CFG_RESET = 24'h000000;
    localparam logic [3:0] FUNC_SPECIAL = 4'hF;

    localparam logic [1:0] SEL_CLK_A = 2'h0;
    localparam logic [1:0] SEL_CLK_B = 2'h1;
    localparam logic [1:0] SEL_LOW_FREQ = 2'h2;
    localparam logic [1:0] SEL_CLK_D = 2'h3;

    localparam logic [23:0] RATIO_MIN = 24'h000002;
    localparam logic [23:0] RATIO_ONE = 24'h000001;
    localparam logic [15:0] RATE_ONE = 16'h0001;
    localparam logic [15:0] RATE_ZERO = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // field order matches bits 23..0 of the register
    typedef struct packed {
        logic [3:0] func;
        logic gci;
        logic neg_pol;
        logic [1:0] sel;
        logic [15:0] rate;
    } pdfp_cfg_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdfp_reg_req_t;

    // sibling post-divider clocks of the same synthesizer
    typedef struct packed {
        logic a;
        logic b;
        logic d;
    } pdfp_sib_t;

    typedef enum logic [1:0] {
        MODE_DIV = 2'b00,
        MODE_LOW_FREQ = 2'b01,
        MODE_FRAME = 2'b10
    } pdfp_mode_t;

endpackage

// file: src/pdfp_cfg_regs.sv
/*
 Configuration register of post-divider C: byte-wide write port, a shadow
 copy, and an atomic commit once every byte has been written.
 Assumes the byte port is driven by logic on i_mclk.
*/
`timescale 1ns/10ps
module pdfp_cfg_regs
    import pdfp_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire pdfp_reg_req_t i_req,
    output pdfp_cfg_t o_cfg,
    output logic o_commit
);

    typedef struct packed {
        logic [23:0] shadow;
        logic [CFG_BYTES-1:0] written;
        pdfp_cfg_t cfg;
        logic commit;
    } pdfp_cfg_state_t;

    pdfp_cfg_state_t s_q;
    pdfp_cfg_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.commit = 1'b0;
        if (i_req.wr) begin
            for (int i = 0; i < CFG_BYTES; i++) begin
                if (i_req.addr == ADDR_CFG_LO - 8'(i)) begin
                    s_d.shadow[i*BYTE_W +: BYTE_W] = i_req.wdata;
                    s_d.written[i] = 1'b1;
                end
            end
        end
        // half-written ratios never reach the counters
        if (&s_d.written) begin // RULE13
            s_d.cfg = pdfp_cfg_t'(s_d.shadow);
            s_d.written = '0;
            s_d.commit = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q <= '{shadow: CFG_RESET, written: '0, cfg: CFG_RESET, commit: 1'b0}; // RULE12
        end else begin
            s_q <= s_d;
        end
    end

    assign o_cfg = s_q.cfg;
    assign o_commit = s_q.commit;

    AST_CFG_RESET: assert property (@(posedge i_mclk) $past(i_rst) |-> o_cfg == CFG_RESET) // RULE12
        else $error("configuration not zero after reset");

    AST_CFG_ATOMIC: assert property (@(posedge i_mclk) disable iff (i_rst)
        !o_commit |-> o_cfg == $past(o_cfg)) // RULE13
        else $error("configuration changed without a full write");

endmodule

// file: src/pdfp_clk_div.sv
/*
 Generic 50% duty divider: counts enable ticks, toggles its clock after
 each half period; odd ratios give the extra tick to the high phase.
 Assumes ratio is held steady between restarts.
*/
`timescale 1ns/10ps
module pdfp_clk_div
    import pdfp_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_restart,
    input wire logic i_tick,
    input wire logic [23:0] i_ratio,
    output logic o_clk
);

    typedef struct packed {
        logic [23:0] cnt;
        logic clk;
    } pdfp_div_state_t;

    pdfp_div_state_t s_q;
    pdfp_div_state_t s_d;
    logic [23:0] half_len;

    always_comb begin
        s_d = s_q;
        half_len = s_q.clk ? (i_ratio - (i_ratio >> 1)) : (i_ratio >> 1);
        // ratios 0 and 1 cannot be made from a registered output; park low
        if (i_restart || i_ratio < RATIO_MIN) begin
            s_d = '0;
        end else if (i_tick) begin
            if (s_q.cnt >= half_len - RATIO_ONE) begin // RULE10
                s_d.cnt = '0;
                s_d.clk = ~s_q.clk;
            end else begin
                s_d.cnt = s_q.cnt + RATIO_ONE;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_clk = s_q.clk;

    AST_DIV_TOGGLE: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!i_restart && i_tick && i_ratio >= RATIO_MIN && s_q.cnt >= half_len - RATIO_ONE)
        |=> o_clk != $past(o_clk)) // RULE10
        else $error("divider missed its half-period toggle");

    AST_DIV_HOLD: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!i_restart && !i_tick) |=> o_clk == $past(o_clk)) // RULE10
        else $error("divider toggled without a tick");

endmodule

// file: testbench/pdfp_out_mon.sv
/*
 Downstream consumer of post-divider C output: measures the length of the
 last high run and last low run, and counts edges.
 Assumes the output is a level made on i_mclk.
*/
`timescale 1ns/10ps
module pdfp_out_mon (
    input wire logic i_mclk,
    input wire logic i_out,
    output logic [7:0] o_hi_len,
    output logic [7:0] o_lo_len,
    output logic [15:0] o_edges
);
    logic [7:0] run_q = 8'h00;
    logic last_q = 1'b0;
    initial begin
        o_hi_len = 8'h00;
        o_lo_len = 8'h00;
        o_edges = 16'h0000;
    end
    // a run is only trusted once bounded by two edges
    // sampled away from the launching edge to stay clear of the output update
    always @(negedge i_mclk) begin
        if (i_out !== last_q) begin
            if (last_q === 1'b1) begin
                o_hi_len <= run_q;
            end else begin
                o_lo_len <= run_q;
            end
            run_q <= 8'h01;
            o_edges <= o_edges + 16'h0001;
        end else begin
            run_q <= run_q + 8'h01;
        end
        last_q <= i_out;
    end
endmodule

// file: testbench/test_pdfp_post_divider.sv
/*
 Self-checking bench of post-divider C: byte writes, readback, and the
 output waveform in every mode, measured by the consumer model.
 Assumes sibling clocks and base tick come from free counters on i_mclk.
*/
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module test_pdfp_post_divider;
    import pdfp_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    pdfp_reg_req_t i_reg = '0;
    logic i_base_tick = 1'b0;
    pdfp_sib_t i_sib = '0;
    logic [7:0] o_reg_rdata;
    logic o_out;
    logic [7:0] hi_len;
    logic [7:0] lo_len;
    logic [15:0] edges;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;

    pdfp_post_divider pdfp_post_divider_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg(i_reg),
        .i_base_tick(i_base_tick), .i_sib(i_sib), .o_reg_rdata(o_reg_rdata), .o_out(o_out));
    pdfp_out_mon pdfp_out_mon_i (.i_mclk(i_mclk), .i_out(o_out), .o_hi_len(hi_len),
        .o_lo_len(lo_len), .o_edges(edges));

    always #2 i_mclk = ~i_mclk;

    // sibling periods 4, 6, 8 cycles; base tick every 3 cycles
    always @(negedge i_mclk) begin
        cyc <= cyc + 1;
        i_sib.a <= (cyc % 4) < 2;
        i_sib.b <= (cyc % 6) < 3;
        i_sib.d <= (cyc % 8) < 4;
        i_base_tick <= (cyc % 3) == 0;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        i_reg.wr = 1'b1;
        i_reg.addr = a;
        i_reg.wdata = d;
        @(negedge i_mclk);
        i_reg.wr = 1'b0;
    endtask

    // back to back bytes, strobe held high across all three
    task automatic write_cfg(input logic [23:0] v);
        @(negedge i_mclk);
        i_reg.wr = 1'b1;
        i_reg.addr = ADDR_CFG_HI;
        i_reg.wdata = v[23:16];
        @(negedge i_mclk);
        i_reg.addr = ADDR_CFG_MID;
        i_reg.wdata = v[15:8];
        @(negedge i_mclk);
        i_reg.addr = ADDR_CFG_LO;
        i_reg.wdata = v[7:0];
        @(negedge i_mclk);
        i_reg.wr = 1'b0;
    endtask

    task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_mclk);
        i_reg.addr = a;
        @(negedge i_mclk);
        `CHK("readback", exp, o_reg_rdata)
    endtask

    task automatic read_cfg(input logic [23:0] v);
        read_chk(ADDR_CFG_HI, v[23:16]);
        read_chk(ADDR_CFG_MID, v[15:8]);
        read_chk(ADDR_CFG_LO, v[7:0]);
    endtask

    // six edges so that both recorded runs are whole ones
    task automatic check_wave(input logic [7:0] hi, input logic [7:0] lo);
        logic [15:0] start;
        int i;
        start = edges;
        for (i = 0; i < 400 && (edges - start) < 16'h0006; i++) begin
            @(negedge i_mclk);
        end
        if ((edges - start) < 16'h0006) begin
            n_fail++;
            $display("MISMATCH output edges expected 6 seen %0d", edges - start);
            give_verdict();
        end
        `CHK("high run", hi, hi_len)
        `CHK("low run", lo, lo_len)
    endtask

    task automatic t_reset_values();
        read_cfg(24'h000000);
        `CHK("idle output", 1'b0, o_out)
        write_byte(8'h9D, 8'hA5);
        read_chk(8'h9D, 8'h00);
    endtask

    task automatic t_divided();
        write_cfg(24'h000007);
        read_cfg(24'h000007);
        check_wave(8'h04, 8'h03);
    endtask

    task automatic t_low_freq();
        write_cfg(24'hF20005);
        check_wave(8'h09, 8'h06);
    endtask

    task automatic t_frame_gci_a();
        write_cfg(24'hF80003);
        check_wave(8'h04, 8'h08);
    endtask

    task automatic t_frame_st_b();
        write_cfg(24'hF50003);
        check_wave(8'h0C, 8'h06);
    endtask

    task automatic t_frame_d();
        write_cfg(24'hF30004);
        check_wave(8'h08, 8'h18);
    endtask

    // two bytes only: old setting must stay in force
    task automatic t_partial_write();
        write_byte(ADDR_CFG_HI, 8'h00);
        write_byte(ADDR_CFG_MID, 8'h00);
        read_cfg(24'hF30004);
        check_wave(8'h08, 8'h18);
        write_byte(ADDR_CFG_LO, 8'h04);
        read_cfg(24'h000004);
        check_wave(8'h02, 8'h02);
    endtask

    // reset in mid-run must drop the setting and park the output
    task automatic t_mid_reset();
        @(negedge i_mclk);
        i_rst = 1'b1;
        repeat (2) @(negedge i_mclk);
        i_rst = 1'b0;
        `CHK("output after reset", 1'b0, o_out)
        read_cfg(24'h000000);
    endtask

    initial begin
        repeat (5) @(negedge i_mclk);
        i_rst = 1'b0;
        t_reset_values();
        t_divided();
        t_low_freq();
        t_frame_gci_a();
        t_frame_st_b();
        t_frame_d();
        t_partial_write();
        t_mid_reset();
        give_verdict();
    end
endmodule
